// file: testbench/adc_front_model.sv
// behavioural converter that answers each start taken while idle with one result
`timescale 1ns/1ps
module adc_front_model #(
    parameter logic [15:0] DATA = 16'h0400
) (
    // clock and start requests
    input  wire logic        core_clk,
    input  wire logic        soc,
    input  wire logic        kick,
    input  wire logic        slow,
    // conversion result
    output logic             eoc,
    output logic [15:0]      adc_data
);
    int busy_n = -1;
    int hold_n = 0;

    initial begin
        eoc = 1'b0;
        adc_data = ~DATA;
    end

    // conversion time stays well inside the shortest period
    always @(posedge core_clk) begin
        if ((soc || kick) && busy_n < 0) begin
            busy_n <= slow ? 40 : 6;
        end else if (busy_n > 0) begin
            busy_n <= busy_n - 1;
        end else if (busy_n == 0) begin
            busy_n   <= -1;
            eoc      <= 1'b1;
            adc_data <= DATA;
            hold_n   <= 6;
        end
        // data outlives the sampling window, then goes stale on purpose
        if (hold_n > 0) begin
            hold_n <= hold_n - 1;
        end
        if (hold_n == 4) begin
            eoc <= 1'b0;
        end
        if (hold_n == 1) begin
            adc_data <= ~adc_data;
        end
    end
endmodule

// file: testbench/sequenced_adc_scan_scheduler_tb.sv
// self-checking bench for the adc scan scheduler
`timescale 1ns/1ps
module sequenced_adc_scan_scheduler_tb
    import scan_sched_pkg::*;
;
    logic        core_clk, rst_b, kick, slow, soc, eoc, irq;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic        excitation_range_hi, offset_sample;
    logic [7:0]  awaddr, araddr, excitation_current_dac;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, input_route_select;
    logic [1:0]  bresp, rresp, adc_range, current_route_select;
    logic [15:0] adc_data;
    int          fails, checks;
    // expected range, dac code and offset flag per reading index
    localparam logic [1:0] RNG_T [15] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h1,
        2'h1, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h3, 2'h3};
    localparam logic [7:0] DAC_T [11] = '{8'h00, 8'h80, 8'h80, 8'h80,
        8'h00, 8'h00, 8'h0A, 8'h64, 8'h0A, 8'h64, 8'h00};
    localparam logic [14:0] OFS_T = 15'h1414;
    localparam logic [1:0] CUR_T [15] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2,
        2'h0, 2'h3, 2'h3, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0};

    sequenced_adc_scan_scheduler sequenced_adc_scan_scheduler_i (
        .core_clk(core_clk), .rst_b(rst_b),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .soc(soc), .eoc(eoc), .adc_data(adc_data), .adc_range(adc_range),
        .input_route_select(input_route_select),
        .current_route_select(current_route_select),
        .excitation_current_dac(excitation_current_dac),
        .excitation_range_hi(excitation_range_hi),
        .offset_sample(offset_sample), .irq(irq));
    adc_front_model adc_front_model_i (.core_clk(core_clk), .soc(soc),
        .kick(kick), .slow(slow), .eoc(eoc), .adc_data(adc_data));

    // ************************************************************
    // shared helpers
    // ************************************************************
    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic timeout(input string nm);
        chk(nm, 32'h1, 32'h0);
        close_out();
    endtask

    // both channels offered together, bready held until the answer
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        logic ta, tw, tb;
        int n;
        @(posedge core_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge core_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge core_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) break;
        end
        bready <= 1'b0;
        if (n == 50) timeout("write answer");
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        logic ta, tr;
        int n;
        @(posedge core_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge core_clk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge core_clk);
            if (ta) arvalid <= 1'b0;
            if (tr) break;
        end
        rready <= 1'b0;
        if (n == 50) timeout("read answer");
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(nm, exp, d);
        chk("read resp", RESP_OKAY, r);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        @(negedge core_clk);
        chk("soc idle", 1'b0, soc);
        chk("reading 0 range", RNG_T[0], adc_range);
        rd_chk("ctrl", CTRL_OFS, 32'h0);
        rd_chk("period", PERIOD_OFS, 32'(PERIOD_RST));
        rd_chk("mask", IRQ_MASK_OFS, 32'h0);
        axi_rd(8'h20, d, r);
        chk("unmapped read", RESP_SLVERR, r);
        chk("unmapped data", 32'h0, d);
    endtask

    task automatic t_period();
        logic [1:0] r;
        axi_wr(PERIOD_OFS, 32'h0000_0141, r);
        rd_chk("period 321", PERIOD_OFS, 32'h0000_0141);
        axi_wr(PERIOD_OFS, 32'h0000_0064, r);
        rd_chk("period clamp", PERIOD_OFS, 32'(PERIOD_MIN));
    endtask

    // fifteen conversion ends with the scheduler stopped
    task automatic t_scan();
        int i, n;
        logic [3:0] nx;
        for (i = 0; i < 15; i++) begin
            nx = (i == 14) ? 4'h0 : 4'(i + 1);
            @(posedge core_clk);
            kick <= 1'b1;
            @(posedge core_clk);
            kick <= 1'b0;
            for (n = 0; n < 80 && input_route_select !== nx; n++) begin
                @(negedge core_clk);
            end
            chk("index", nx, input_route_select);
            chk("range", RNG_T[nx], adc_range);
            chk("offset", OFS_T[nx], offset_sample);
            chk("route", CUR_T[nx], current_route_select);
            if (nx >= 4'h1 && nx <= 4'hA) begin
                chk("dac", DAC_T[nx], excitation_current_dac);
                chk("dac hi", nx <= 4'h4, excitation_range_hi);
            end
            repeat (6) @(posedge core_clk);
        end
        rd_chk("irq status", IRQ_STAT_OFS, 32'h7);
        rd_chk("result 0", RESULT_OFS, 32'h0001_0100);
        rd_chk("result 14", RESULT_OFS + 8'h38, 32'h0001_0100);
    endtask

    task automatic t_irq();
        logic [1:0] r;
        chk("irq masked", 1'b0, irq);
        axi_wr(IRQ_MASK_OFS, 32'h1, r);
        @(negedge core_clk);
        chk("irq raised", 1'b1, irq);
        axi_wr(IRQ_STAT_OFS, 32'h1, r);
        @(negedge core_clk);
        chk("irq cleared", 1'b0, irq);
        rd_chk("status left", IRQ_STAT_OFS, 32'h6);
        axi_wr(IRQ_STAT_OFS, 32'h6, r);
        rd_chk("status empty", IRQ_STAT_OFS, 32'h0);
        axi_wr(8'h20, 32'h1, r);
        chk("unmapped write", RESP_SLVERR, r);
        axi_wr(RESULT_OFS, 32'h1, r);
        chk("result write", RESP_SLVERR, r);
    endtask

    // stop mid-period must restart the full interval
    task automatic t_run();
        logic [31:0] d;
        logic [1:0]  r;
        int n;
        slow <= 1'b1;
        axi_wr(CTRL_OFS, 32'h1, r);
        for (n = 0; n < 30000 && soc !== 1'b1; n++) @(negedge core_clk);
        chk("early start", 30000, n);
        axi_wr(CTRL_OFS, 32'h0, r);
        axi_wr(CTRL_OFS, 32'h1, r);
        for (n = 1; n < 64100 && soc !== 1'b1; n++) @(negedge core_clk);
        chk("start spacing", 1'b1, n > 63990 && n < 64010);
        @(negedge core_clk);
        chk("start width", 1'b0, soc);
        axi_wr(CTRL_OFS, 32'h0, r);
        repeat (80) @(posedge core_clk);
        axi_rd(STATUS_OFS, d, r);
        chk("slot count", 32'h0001_0001, d & 32'hFFFF_000F);
        rd_chk("on time", IRQ_STAT_OFS, 32'h1);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rst_b = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        kick = 1'b0;
        slow = 1'b0;
        fails = 0;
        checks = 0;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_period();
        t_scan();
        t_irq();
        t_run();
        close_out();
    end
endmodule

// file: verilog/scan_sched_pkg.sv
// constants and types shared by the adc scan scheduler
package scan_sched_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_FREQ_MHZ   = 200;  // core_clk rate
    localparam int SCAN_PERIOD_US = 606;  // start pulse interval
    localparam int MIN_PERIOD_US  = 320;  // conversion plus handling
    // one scheduler tick is one microsecond of core_clk
    localparam logic [7:0]  TICK_CYCLES   = 8'(CLK_FREQ_MHZ);
    localparam logic [15:0] PERIOD_RST    = 16'(SCAN_PERIOD_US);
    localparam logic [15:0] PERIOD_MIN    = 16'(MIN_PERIOD_US);
    localparam logic [3:0]  NUM_READINGS  = 4'hF;
    localparam logic [3:0]  LAST_READING  = 4'hE;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] PERIOD_OFS    = 8'h04;
    localparam logic [7:0] STATUS_OFS    = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFS  = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFS  = 8'h10;
    localparam logic [7:0] RESULT_OFS    = 8'h40;  // 15 words
    localparam int         RUN_BIT       = 0;
    localparam int         INVALID_BIT   = 16;     // in result words
    localparam int         IRQ_EOC_BIT   = 0;
    localparam int         IRQ_LATE_BIT  = 1;
    localparam int         IRQ_SCAN_BIT  = 2;
    localparam logic       RUN_RST       = 1'b0;
    localparam logic [2:0] IRQ_MASK_RST  = 3'h0;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // ************************************************************
    // signal chain settings
    // ************************************************************
    typedef enum logic [1:0] {
        RANGE_0V064, RANGE_0V256, RANGE_1V024, RANGE_6V144
    } range_e;
    typedef enum logic [1:0] {
        CUR_NONE, CUR_RTD, CUR_REF, CUR_DIODE
    } cur_route_e;
    localparam logic [7:0] DAC_1MA024 = 8'h80;  // 2 mA range, 8 uA lsb
    localparam logic [7:0] DAC_10UA   = 8'h0A;  // 255 uA range, 1 uA lsb
    localparam logic [7:0] DAC_100UA  = 8'h64;
    localparam logic [7:0] DAC_OFF    = 8'h00;

    typedef struct packed {
        range_e     rng;
        cur_route_e cur;
        logic [7:0] dac;
        logic       dac_hi;   // 1: 2 mA range, 0: 255 uA range
        logic       ofs;      // offset sample reading
    } chain_cfg_s;

endpackage

// file: verilog/sequenced_adc_scan_scheduler.sv
// adc scan scheduler with axi4-lite registers and result buffer
`timescale 1ns/1ps
module sequenced_adc_scan_scheduler
    import scan_sched_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // axi4-lite slave
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // converter
    output logic             soc,
    input  wire logic        eoc,
    input  wire logic [15:0] adc_data,
    output logic [1:0]       adc_range,
    // analog front end
    output logic [3:0]       input_route_select,
    output logic [1:0]       current_route_select,
    output logic [7:0]       excitation_current_dac,
    output logic             excitation_range_hi,
    output logic             offset_sample,
    // interrupt
    output logic             irq
);

    // ************************************************************
    // reading table
    // ************************************************************
    // order: 20mV, rtd, rtd ofs, ref, ref ofs, 100mV, diode i1,
    // diode i2, ref i1, ref i2, ref ofs, ic, ic ofs, 3v3, 5v
    function automatic chain_cfg_s cfg_of(input logic [3:0] i);
        chain_cfg_s c;
        c = '{RANGE_0V064, CUR_NONE, DAC_OFF, 1'b0, 1'b0};
        unique case (i)
            4'h0:      c.rng = RANGE_0V064;
            4'h1, 4'h2: c = '{RANGE_0V256, CUR_RTD, DAC_1MA024, 1'b1,
                              i == 4'h2};
            4'h3:      c = '{RANGE_0V256, CUR_REF, DAC_1MA024, 1'b1, 1'b0};
            4'h4:      c = '{RANGE_0V256, CUR_REF, DAC_OFF, 1'b1,
                              1'b1};
            4'h5:      c.rng = RANGE_0V256;
            4'h6:      c = '{RANGE_1V024, CUR_DIODE, DAC_10UA, 1'b0, 1'b0};
            4'h7:      c = '{RANGE_1V024, CUR_DIODE, DAC_100UA, 1'b0, 1'b0};
            4'h8:      c = '{RANGE_0V064, CUR_REF, DAC_10UA, 1'b0, 1'b0};
            4'h9:      c = '{RANGE_0V064, CUR_REF, DAC_100UA, 1'b0, 1'b0};
            4'hA:      c = '{RANGE_0V064, CUR_REF, DAC_OFF, 1'b0, 1'b1};
            4'hB:      c.rng = RANGE_1V024;
            4'hC:      c = '{RANGE_1V024, CUR_NONE, DAC_OFF, 1'b0, 1'b1};
            4'hD, 4'hE: c.rng = RANGE_6V144;
            default:   c.rng = RANGE_0V064;  // code F never selected
        endcase
        return c;
    endfunction

    // merge a write under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [2:0]              eoc_sync;
        logic                    eoc_lvl;   // filtered pin level
        logic                    run;
        logic [15:0]             period;
        logic [7:0]              presc;
        logic [15:0]             per_cnt;
        logic                    soc;
        logic [15:0]             slot;
        logic [15:0]             rd_cnt;
        logic [3:0]              idx;
        logic                    fill;      // bank being filled
        logic [2:0]              irq_st;
        logic [2:0]              irq_mask;
        chain_cfg_s              cfg;
        logic [14:0][15:0]       filt;
        logic [1:0][14:0][16:0]  res_mem;
        logic                    aw_ok;
        logic [7:0]              aw_a;
        logic                    w_ok;
        logic [31:0]             w_d;
        logic [3:0]              w_s;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
    } state_s;

    state_s st_q;
    state_s st_d;
    logic   eoc_evt;
    logic   tick_end;
    logic   per_end;

    // a rise counts once the second and third stages both read high
    assign eoc_evt  = st_q.eoc_sync[1] & st_q.eoc_sync[2]
                    & ~st_q.eoc_lvl;
    assign tick_end = st_q.presc == TICK_CYCLES - 8'h01;
    assign per_end  = st_q.per_cnt == st_q.period - 16'h0001;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [31:0] wv;
        logic [31:0] rv;
        logic [2:0]  set;
        logic [16:0] diff;
        logic [15:0] nf;
        logic        late;
        wv   = '0;
        rv   = '0;
        set  = '0;
        diff = '0;
        nf   = '0;
        late = 1'b0;
        st_d = st_q;
        st_d.eoc_sync = {st_q.eoc_sync[1:0], eoc};
        if (st_q.eoc_sync[1] == st_q.eoc_sync[2]) begin
            st_d.eoc_lvl = st_q.eoc_sync[2];
        end
        st_d.soc = 1'b0;

        // scheduler: 1 us prescaler feeding the 16-bit period counter
        if (!st_q.run) begin
            st_d.presc   = '0;
            st_d.per_cnt = '0;
        end else if (tick_end) begin
            st_d.presc = '0;
            if (per_end) begin
                st_d.per_cnt = '0;
                st_d.soc     = 1'b1;
                st_d.slot    = st_q.slot + 16'h0001;
            end else begin
                st_d.per_cnt = st_q.per_cnt + 16'h0001;
            end
        end else begin
            st_d.presc = st_q.presc + 8'h01;
        end

        // conversion end: filter, store, step to the next reading
        if (eoc_evt) begin
            late = st_q.slot != st_q.rd_cnt + 16'h0001;
            st_d.rd_cnt = st_q.slot;  // resync so one slip flags once
            diff = {adc_data[15], adc_data}
                 - {st_q.filt[st_q.idx][15], st_q.filt[st_q.idx]};
            // first-order low pass, weight 1/4; hum rejection trade-off
            nf = st_q.filt[st_q.idx] + 16'(signed'(diff) >>> 2);
            st_d.filt[st_q.idx] = nf;
            st_d.res_mem[st_q.fill][st_q.idx] = {late, nf};
            set[IRQ_EOC_BIT]  = 1'b1;
            set[IRQ_LATE_BIT] = late;
            if (st_q.idx == LAST_READING) begin
                st_d.idx  = '0;
                st_d.fill = ~st_q.fill;
                set[IRQ_SCAN_BIT] = 1'b1;
            end else begin
                st_d.idx = st_q.idx + 4'h1;
            end
            st_d.cfg = cfg_of(st_d.idx);
        end

        // write channel: address and data taken in either order
        if (awvalid && awready) begin
            st_d.aw_ok = 1'b1;
            st_d.aw_a  = awaddr;
        end
        if (wvalid && wready) begin
            st_d.w_ok = 1'b1;
            st_d.w_d  = wdata;
            st_d.w_s  = wstrb;
        end
        if (st_q.aw_ok && st_q.w_ok) begin
            st_d.aw_ok  = 1'b0;
            st_d.w_ok   = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = RESP_OKAY;
            unique case (st_q.aw_a & 8'hFC)
                CTRL_OFS: begin
                    wv = merge({31'h0, st_q.run}, st_q.w_d, st_q.w_s);
                    st_d.run = wv[RUN_BIT];
                end
                PERIOD_OFS: begin
                    wv = merge({16'h0, st_q.period}, st_q.w_d, st_q.w_s);
                    // clamp so a start never outruns the handling
                    st_d.period = (wv[15:0] < PERIOD_MIN) ? PERIOD_MIN
                                                          : wv[15:0];
                end
                IRQ_STAT_OFS: begin
                    wv = merge('0, st_q.w_d, st_q.w_s);
                    st_d.irq_st = st_q.irq_st & ~wv[2:0];
                end
                IRQ_MASK_OFS: begin
                    wv = merge({29'h0, st_q.irq_mask}, st_q.w_d,
                               st_q.w_s);
                    st_d.irq_mask = wv[2:0];
                end
                STATUS_OFS: ;
                default: st_d.bresp = RESP_SLVERR;
            endcase
        end
        // hardware set wins over a same-cycle clear
        st_d.irq_st = st_d.irq_st | set;
        if (st_q.bvalid && bready) begin
            st_d.bvalid = 1'b0;
        end

        // read channel
        if (arvalid && arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = RESP_OKAY;
            if (araddr >= RESULT_OFS
                    && araddr[5:2] != NUM_READINGS) begin
                // readers see the bank that is not being filled
                rv = {15'h0, st_q.res_mem[~st_q.fill][araddr[5:2]]};
            end else begin
                unique case (araddr & 8'hFC)
                    CTRL_OFS:     rv = {31'h0, st_q.run};
                    PERIOD_OFS:   rv = {16'h0, st_q.period};
                    STATUS_OFS:   rv = {st_q.slot, 7'h0, ~st_q.fill,
                                        4'h0, st_q.idx};
                    IRQ_STAT_OFS: rv = {29'h0, st_q.irq_st};
                    IRQ_MASK_OFS: rv = {29'h0, st_q.irq_mask};
                    default:      st_d.rresp = RESP_SLVERR;
                endcase
            end
            st_d.rdata = rv;
        end else if (st_q.rvalid && rready) begin
            st_d.rvalid = 1'b0;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_q          <= '0;
            st_q.run      <= RUN_RST;
            st_q.period   <= PERIOD_RST;
            st_q.irq_mask <= IRQ_MASK_RST;
            st_q.cfg      <= cfg_of(4'h0);
        end else begin
            st_q <= st_d;
        end
    end

    // outputs
    assign awready                = !st_q.aw_ok && !st_q.bvalid;
    assign wready                 = !st_q.w_ok && !st_q.bvalid;
    assign bvalid                 = st_q.bvalid;
    assign bresp                  = st_q.bresp;
    assign arready                = !st_q.rvalid;
    assign rvalid                 = st_q.rvalid;
    assign rdata                  = st_q.rdata;
    assign rresp                  = st_q.rresp;
    assign soc                    = st_q.soc;
    assign adc_range              = st_q.cfg.rng;
    assign input_route_select     = st_q.idx;
    assign current_route_select   = st_q.cfg.cur;
    assign excitation_current_dac = st_q.cfg.dac;
    assign excitation_range_hi    = st_q.cfg.dac_hi;
    assign offset_sample          = st_q.cfg.ofs;
    assign irq                    = |(st_q.irq_st & st_q.irq_mask);

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    chk_soc_on_wrap: assert property (
        st_q.run && tick_end && per_end |=> soc)
        else $error("start pulse missing at period end");
    chk_soc_gated: assert property (
        !st_q.run |=> !soc)
        else $error("start pulse while stopped");
    chk_period_floor: assert property (
        st_q.period >= PERIOD_MIN)
        else $error("period below minimum");
    chk_slot_count: assert property (
        soc |-> st_q.slot == $past(st_q.slot) + 16'h0001)
        else $error("slot count did not follow start pulse");
    chk_eoc_flag: assert property (
        eoc_evt |=> st_q.irq_st[IRQ_EOC_BIT])
        else $error("conversion end not flagged");
    chk_late_mark: assert property (
        eoc_evt && st_q.slot != st_q.rd_cnt + 16'h0001
        |=> st_q.irq_st[IRQ_LATE_BIT]
            && st_q.res_mem[st_q.fill ^ (st_q.idx == 4'h0)]
                [$past(st_q.idx)][INVALID_BIT])
        else $error("late reading not marked");
    chk_cfg_step: assert property (
        eoc_evt && st_q.idx != LAST_READING
        |=> input_route_select == $past(st_q.idx) + 4'h1
            && adc_range == cfg_of(input_route_select).rng)
        else $error("chain not set for next reading");
    chk_index_wrap: assert property (
        eoc_evt && st_q.idx == LAST_READING
        |=> st_q.idx == 4'h0 && st_q.fill != $past(st_q.fill))
        else $error("index did not wrap with bank swap");
    chk_index_range: assert property (
        st_q.idx <= LAST_READING)
        else $error("reading index out of range");
    chk_rail_range: assert property (
        st_q.idx >= 4'hD |-> adc_range == RANGE_6V144)
        else $error("rail reading not on widest range");

    cov_scan_wrap: cover property (
        eoc_evt && st_q.idx == LAST_READING);
    cov_late: cover property (eoc_evt && st_q.slot != st_q.rd_cnt + 16'h1);
    cov_stop: cover property (st_q.run ##1 !st_q.run);
    cov_irq: cover property (irq);

endmodule
